// file: rtl/mrb_core.sv
// Mode register 0/1 behaviour: burst order, chop, latency, recovery,
// write CRC discard and DLL control, with an APB register port.
// Assumes commands arrive on pclk from logic on the same clock.
//
// Summary of operation
// R1: Burst type bit picks sequential or interleaved.
// R2: Length field picks fixed chop, fixed eight, on-the-fly.
// R3: On-the-fly length sampled from A12 with command.
// R4: Sequential reads wrap inside aligned group of four.
// R5: Interleaved read beat column is start XOR beat.
// R6: Chopped read tristates data for last four slots.
// R7: Chopped write uses A2 only, drops last four.
// R8: Eight-beat write stores words zero to seven.
// R9: Fixed chop starts internal write two clocks early.
// R10: On-the-fly chop keeps eight-beat write timing.
// R11: First read data after additive plus CAS latency.
// R12: Controller keeps test mode bit at zero.
// R13: Write recovery field times auto-precharge.
// R14: CRC error with mask enabled discards write.
// R15: Read-to-precharge field times precharge after read.
// R16: DLL reset bit clears itself after use.
// R17: Controller waits lock time after DLL reset.
// R18: Controller holds clock enable high during lock.
// R19: DLL off in self refresh, back on exit.
// R20: Controller disables nominal termination in DLL-off.
// R21: Controller disables dynamic termination in DLL-off.
// R22: Mode write to select code seven is ignored.
// R23: Writes need DLL only with dynamic termination.
// R24: Recovery codes map to fixed clock pairs.
//
// Register access over APB and the address map were decided locally.
module mrb_core #(
  parameter int DW = 8,
  parameter int TDLLK = mrb_pkg::TDLLK_CLK
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Command port from the controller
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_op,
  input wire logic cmd_bg0,
  input wire logic [1:0] cmd_ba,
  input wire logic [13:0] cmd_addr,
  // Write data beats
  input wire logic wbeat_valid,
  input wire logic [DW-1:0] wbeat_data,
  input wire logic wcrc_err,
  // Read burst beats
  output logic rd_vld,
  output logic rd_oe,
  output logic [2:0] rd_col,
  // Array write side
  output logic arr_we,
  output logic [2:0] arr_col,
  output logic [DW-1:0] arr_data,
  output logic wr_start,
  output logic wr_drop,
  output logic pre_go,
  // DLL state
  output logic dll_on,
  output logic dll_locked
);
  typedef enum logic [1:0] {MRB_RIDLE, MRB_RLAT, MRB_RBURST} mrb_rst_t;
  typedef enum logic [1:0] {MRB_WIDLE, MRB_WCAP, MRB_WCOMMIT} mrb_wst_t;

  logic [13:0] mr0_r, mr1_r;
  logic [12:0] ctrl_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r, drop_seen_r;
  mrb_rst_t rst_r;
  mrb_wst_t wst_r;
  logic [5:0] rlat_r;
  logic [2:0] rbeat_r, rstart_r, wbeat_r, cbeat_r;
  logic rchop_r, rd_vld_r, rd_oe_r;
  logic [2:0] rd_col_r;
  logic wchop_r, wfix4_r, whi_r, wap_r;
  logic [DW-1:0] wbuf [8];
  logic arr_we_r, wr_start_r, wr_drop_r, pre_go_r;
  logic [2:0] arr_col_r;
  logic [DW-1:0] arr_data_r;
  logic [5:0] pre_cnt_r;
  logic in_sr_r, dll_on_r, dll_locked_r;
  logic [15:0] lock_cnt_r;

  // Decoded settings
  logic [1:0] bl_mode;
  logic bt_ilv, mrs_ok, rd_cmd, wr_cmd, crc_dm;
  logic [5:0] rl, wr_clk, rtp_clk;
  assign bl_mode = mr0_r[mrb_pkg::MR0_BL_LSB +: 2];
  assign bt_ilv = mr0_r[mrb_pkg::MR0_BT_BIT];
  assign rl = 6'(ctrl_r[mrb_pkg::CTRL_CL_LSB +: 5])
            + 6'(ctrl_r[mrb_pkg::CTRL_AL_LSB +: 5]); // R11
  assign crc_dm = ctrl_r[mrb_pkg::CTRL_CRC_BIT]
                & ctrl_r[mrb_pkg::CTRL_DM_BIT];
  // Select code seven is for register words, not this device
  assign mrs_ok = cmd_valid && cmd_op == 3'(mrb_pkg::MRB_MRS)
               && !(cmd_bg0 && cmd_ba == 2'h3); // R22
  assign rd_cmd = cmd_valid && cmd_op == 3'(mrb_pkg::MRB_RD);
  assign wr_cmd = cmd_valid && cmd_op == 3'(mrb_pkg::MRB_WR);

  // Recovery and read-to-precharge clocks per field code
  always_comb begin
    unique case (mr0_r[mrb_pkg::MR0_WR_LSB +: 3]) // R13 R15 R24
      3'h0: begin wr_clk = 6'd10; rtp_clk = 6'd5; end
      3'h1: begin wr_clk = 6'd12; rtp_clk = 6'd6; end
      3'h2: begin wr_clk = 6'd14; rtp_clk = 6'd7; end
      3'h3: begin wr_clk = 6'd16; rtp_clk = 6'd8; end
      3'h4: begin wr_clk = 6'd18; rtp_clk = 6'd9; end
      3'h5: begin wr_clk = 6'd20; rtp_clk = 6'd10; end
      3'h6: begin wr_clk = 6'd24; rtp_clk = 6'd12; end
      default: begin wr_clk = 6'd24; rtp_clk = 6'd12; end
    endcase
  end

  // Column of read beat n from the start column
  function automatic logic [2:0] beat_col(input logic [2:0] s,
      input logic [2:0] n, input logic ilv);
    if (ilv) begin
      beat_col = s ^ n; // R5
    end else begin
      beat_col = {s[2] ^ n[2], 2'(s[1:0] + n[1:0])}; // R4
    end
  endfunction

  // APB slave: no wait state, answer in first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel && !penable && !pready_r;
      if (psel && !penable) begin
        pslverr_r <= paddr > mrb_pkg::ADDR_STAT || paddr[1:0] != 2'h0;
        unique case (paddr)
          mrb_pkg::ADDR_MR0: prdata_r <= {18'h0, mr0_r};
          mrb_pkg::ADDR_MR1: prdata_r <= {18'h0, mr1_r};
          mrb_pkg::ADDR_CTRL: prdata_r <= {19'h0, ctrl_r};
          mrb_pkg::ADDR_STAT: prdata_r <= {26'h0, drop_seen_r,
            ctrl_r[mrb_pkg::CTRL_RTTWR_BIT] && !dll_locked_r, // R23
            mr0_r[mrb_pkg::MR0_WR_LSB +: 3] == mrb_pkg::WR_RSVD,
            mr0_r[mrb_pkg::MR0_TM_BIT], dll_locked_r, dll_on_r}; // R12
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Mode registers: by MRS command or APB; DLL reset bit self-clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mr0_r <= mrb_pkg::MR0_RST;
      mr1_r <= mrb_pkg::MR1_RST;
      ctrl_r <= mrb_pkg::CTRL_RST;
    end else begin
      if (mr0_r[mrb_pkg::MR0_DLLRST_BIT]) begin
        mr0_r[mrb_pkg::MR0_DLLRST_BIT] <= 1'b0; // R16
      end
      if (mrs_ok && cmd_ba == 2'h0 && !cmd_bg0) begin
        mr0_r <= cmd_addr;
      end else if (mrs_ok && cmd_ba == 2'h1 && !cmd_bg0) begin
        mr1_r <= cmd_addr;
      end
      if (pready_r && psel && penable && pwrite) begin
        unique case (paddr)
          mrb_pkg::ADDR_MR0: mr0_r <= pwdata[13:0];
          mrb_pkg::ADDR_MR1: mr1_r <= pwdata[13:0];
          mrb_pkg::ADDR_CTRL: ctrl_r <= pwdata[12:0];
          default: ;
        endcase
      end
    end
  end

  // DLL: off in self refresh, relock count after reset or exit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_sr_r <= 1'b0;
      dll_on_r <= 1'b0;
      dll_locked_r <= 1'b0;
      lock_cnt_r <= 16'h0000;
    end else begin
      if (cmd_valid && cmd_op == 3'(mrb_pkg::MRB_SRE)) begin
        in_sr_r <= 1'b1;
      end else if (cmd_valid && cmd_op == 3'(mrb_pkg::MRB_SRX)) begin
        in_sr_r <= 1'b0;
      end
      dll_on_r <= mr1_r[mrb_pkg::MR1_DLLEN_BIT] && !in_sr_r; // R19
      if (!dll_on_r || in_sr_r) begin
        dll_locked_r <= 1'b0; // R19
        lock_cnt_r <= 16'(TDLLK);
      end else if (mr0_r[mrb_pkg::MR0_DLLRST_BIT]) begin
        dll_locked_r <= 1'b0;
        lock_cnt_r <= 16'(TDLLK);
      end else if (lock_cnt_r != 16'h0000) begin
        lock_cnt_r <= lock_cnt_r - 16'h0001;
        dll_locked_r <= lock_cnt_r == 16'h0001;
      end
    end
  end

  // Read burst: latency count then eight slots
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_r <= MRB_RIDLE;
      rlat_r <= 6'h00;
      rbeat_r <= 3'h0;
      rstart_r <= 3'h0;
      rchop_r <= 1'b0;
      rd_vld_r <= 1'b0;
      rd_oe_r <= 1'b0;
      rd_col_r <= 3'h0;
    end else begin
      rd_vld_r <= 1'b0;
      rd_oe_r <= 1'b0;
      unique case (rst_r)
        MRB_RIDLE: if (rd_cmd) begin
          rst_r <= MRB_RLAT;
          rlat_r <= (rl == 6'h00) ? 6'h01 : rl;
          rstart_r <= cmd_addr[2:0];
          rchop_r <= bl_mode == mrb_pkg::BL_FIX4
            || (bl_mode == mrb_pkg::BL_OTF
                && !cmd_addr[mrb_pkg::COL_BC_BIT]); // R2 R3
        end
        MRB_RLAT: begin
          rlat_r <= rlat_r - 6'h01;
          if (rlat_r == 6'h01) begin
            rst_r <= MRB_RBURST;
            rbeat_r <= 3'h1;
            rd_vld_r <= 1'b1;
            rd_oe_r <= 1'b1;
            rd_col_r <= rstart_r; // R11
          end
        end
        MRB_RBURST: begin
          rbeat_r <= rbeat_r + 3'h1;
          if (rbeat_r == mrb_pkg::LAST_SLOT) begin
            rst_r <= MRB_RIDLE;
          end
          rd_vld_r <= !rchop_r || !rbeat_r[2];
          rd_oe_r <= !rchop_r || !rbeat_r[2]; // R6
          rd_col_r <= beat_col(rstart_r, rbeat_r, bt_ilv); // R1
        end
        default: rst_r <= MRB_RIDLE;
      endcase
    end
  end

  // Write: capture eight slots, then commit unless CRC failed with CRC and DM both enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wst_r <= MRB_WIDLE;
      wbeat_r <= 3'h0;
      cbeat_r <= 3'h0;
      wchop_r <= 1'b0;
      wfix4_r <= 1'b0;
      whi_r <= 1'b0;
      wap_r <= 1'b0;
      arr_we_r <= 1'b0;
      arr_col_r <= 3'h0;
      arr_data_r <= '0;
      wr_start_r <= 1'b0;
      wr_drop_r <= 1'b0;
    end else begin
      arr_we_r <= 1'b0;
      wr_start_r <= 1'b0;
      wr_drop_r <= 1'b0;
      unique case (wst_r)
        MRB_WIDLE: if (wr_cmd) begin
          wst_r <= MRB_WCAP;
          wbeat_r <= 3'h0;
          wfix4_r <= bl_mode == mrb_pkg::BL_FIX4;
          wchop_r <= bl_mode == mrb_pkg::BL_FIX4
            || (bl_mode == mrb_pkg::BL_OTF
                && !cmd_addr[mrb_pkg::COL_BC_BIT]); // R3
          whi_r <= cmd_addr[2]; // R7
          wap_r <= cmd_addr[mrb_pkg::COL_AP_BIT];
        end
        MRB_WCAP: if (wbeat_valid) begin
          wbuf[wbeat_r] <= wbeat_data;
          wbeat_r <= wbeat_r + 3'h1;
          wr_start_r <= wfix4_r ? wbeat_r == mrb_pkg::EARLY_SLOT
                                : wbeat_r == mrb_pkg::LAST_SLOT; // R9 R10
          if (wbeat_r == mrb_pkg::LAST_SLOT) begin
            cbeat_r <= 3'h0;
            if (crc_dm && wcrc_err) begin
              wst_r <= MRB_WIDLE;
              wr_drop_r <= 1'b1; // R14
            end else begin
              wst_r <= MRB_WCOMMIT;
            end
          end
        end
        MRB_WCOMMIT: begin
          cbeat_r <= cbeat_r + 3'h1;
          arr_we_r <= 1'b1;
          arr_data_r <= wbuf[cbeat_r];
          arr_col_r <= wchop_r ? {whi_r, cbeat_r[1:0]} : cbeat_r; // R7 R8
          if (cbeat_r == (wchop_r ? mrb_pkg::CHOP_LAST
                                  : mrb_pkg::LAST_SLOT)) begin
            wst_r <= MRB_WIDLE;
          end
        end
        default: wst_r <= MRB_WIDLE;
      endcase
    end
  end

  // Auto-precharge timer from read command or internal write start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_r <= 6'h00;
      pre_go_r <= 1'b0;
      drop_seen_r <= 1'b0;
    end else begin
      pre_go_r <= pre_cnt_r == 6'h01;
      if (rst_r == MRB_RIDLE && rd_cmd && cmd_addr[mrb_pkg::COL_AP_BIT]) begin
        pre_cnt_r <= 6'(ctrl_r[mrb_pkg::CTRL_AL_LSB +: 5]) + rtp_clk; // R15
      end else if (wr_start_r && wap_r) begin
        pre_cnt_r <= wr_clk; // R13
      end else if (pre_cnt_r != 6'h00) begin
        pre_cnt_r <= pre_cnt_r - 6'h01;
      end
      drop_seen_r <= wr_drop_r || (drop_seen_r && !(pready_r && psel
        && penable && !pwrite && paddr == mrb_pkg::ADDR_STAT));
    end
  end

  // Output ports
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign rd_vld = rd_vld_r;
  assign rd_oe = rd_oe_r;
  assign rd_col = rd_col_r;
  assign arr_we = arr_we_r;
  assign arr_col = arr_col_r;
  assign arr_data = arr_data_r;
  assign wr_start = wr_start_r;
  assign wr_drop = wr_drop_r;
  assign pre_go = pre_go_r;
  assign dll_on = dll_on_r;
  assign dll_locked = dll_locked_r;

  // Checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_burst_open;
    rst_r == MRB_RLAT && rlat_r == 6'h01;
  endsequence
  sequence s_chop_tail;
    (rd_vld_r && rd_oe_r) [*4] ##1 (!rd_oe_r && !rd_vld_r) [*4];
  endsequence

  a_dll_rst_clear: assert property ( // R16
    mr0_r[mrb_pkg::MR0_DLLRST_BIT] |=> !mr0_r[mrb_pkg::MR0_DLLRST_BIT]
      || $past(mrs_ok))
    else $error("dll reset bit did not clear");
  a_ignore_mrs_seven: assert property ( // R22
    cmd_valid && cmd_op == 3'(mrb_pkg::MRB_MRS) && cmd_bg0
      && cmd_ba == 2'h3 && !(pready_r && psel && penable && pwrite)
    |=> $stable(mr0_r) || $past(mr0_r[mrb_pkg::MR0_DLLRST_BIT]))
    else $error("mode write with select seven changed mr0");
  a_chop_read_tail: assert property ( // R6
    s_burst_open ##0 rchop_r |=> s_chop_tail)
    else $error("chopped read did not tristate last four slots");
  a_read_latency: assert property ( // R11
    rst_r == MRB_RIDLE && rd_cmd && rl == 6'h05
    |=> !rd_vld_r [*5] ##1 rd_vld_r)
    else $error("first read beat not at al plus cl");
  a_seq_wrap: assert property ( // R4
    rd_vld_r && !bt_ilv && rst_r == MRB_RBURST
    |-> rd_col_r[2] == (rstart_r[2] ^ $past(rbeat_r[2])))
    else $error("sequential burst left its group");
  a_ilv_order: assert property ( // R5
    rst_r == MRB_RBURST && bt_ilv && rbeat_r != 3'h0
    |=> rd_col_r == (rstart_r ^ $past(rbeat_r)))
    else $error("interleaved column wrong");
  a_crc_discard: assert property ( // R14
    wr_drop_r |-> !arr_we_r [*8])
    else $error("array written after crc error");
  a_self_refresh_dll: assert property ( // R19
    in_sr_r |=> !dll_on_r && !dll_locked_r)
    else $error("dll on during self refresh");
  a_early_start: assert property ( // R9
    wst_r == MRB_WCAP && wbeat_valid && wfix4_r
      && wbeat_r == mrb_pkg::EARLY_SLOT |=> wr_start_r)
    else $error("fixed chop write did not start early");
  a_wr_recovery: assert property ( // R13
    wr_start_r && wap_r && wr_clk == 6'd10 && rst_r == MRB_RIDLE
      && !rd_cmd |=> ##10 pre_go_r)
    else $error("auto-precharge not after recovery");
endmodule

// file: rtl/mrb_pkg.sv
// Constants for the mode register burst and DLL control block.
// Assumes a single 100 MHz clock and an APB register port.
package mrb_pkg;
  // Clock period and DLL lock figure
  localparam int CLK_PERIOD_NS = 10;
  localparam int TDLLK_CLK = 512;
  // APB register byte offsets
  localparam logic [7:0] ADDR_MR0 = 8'h00;
  localparam logic [7:0] ADDR_MR1 = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  // Mode register 0/1 fields, column address bits and reset values
  localparam int MR0_BL_LSB = 0;
  localparam int MR0_BT_BIT = 3;
  localparam int MR0_TM_BIT = 7;
  localparam int MR0_DLLRST_BIT = 8;
  localparam int MR0_WR_LSB = 9;
  localparam int MR1_DLLEN_BIT = 0;
  localparam int COL_AP_BIT = 10;
  localparam int COL_BC_BIT = 12;
  localparam logic [13:0] MR0_RST = 14'h0000;
  localparam logic [13:0] MR1_RST = 14'h0000;
  // Burst length and write recovery field codes
  localparam logic [1:0] BL_FIX8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIX4 = 2'h2;
  localparam logic [2:0] WR_RSVD = 3'h7;
  // Control register fields
  localparam int CTRL_CL_LSB = 0;
  localparam int CTRL_AL_LSB = 5;
  localparam int CTRL_CRC_BIT = 10;
  localparam int CTRL_DM_BIT = 11;
  localparam int CTRL_RTTWR_BIT = 12;
  localparam logic [12:0] CTRL_RST = 13'h0009;
  // Beat slots of a burst, and the early write point for fixed chop
  localparam logic [2:0] LAST_SLOT = 3'h7;
  localparam logic [2:0] CHOP_LAST = 3'h3;
  localparam logic [2:0] EARLY_SLOT = 3'h5;
  // Status bit positions
  localparam int ST_DLLON = 0;
  localparam int ST_LOCK = 1;
  localparam int ST_TM = 2;
  localparam int ST_WRRSVD = 3;
  localparam int ST_WRDLL = 4;
  localparam int ST_DROP = 5;
  // Command codes
  typedef enum logic [2:0] {
    MRB_NOP, MRB_MRS, MRB_RD, MRB_WR, MRB_SRE, MRB_SRX
  } mrb_cmd_t;
endpackage

// file: verif/ddr4_mr0_mr1_burst_dll_control_test.sv
// Self-checking bench: registers, burst order, writes, DLL.
// Assumes mrb_ctl_model on the command port, lock count cut to 8.
module ddr4_mr0_mr1_burst_dll_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TDL = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, cmd_valid, cmd_bg0, wbeat_valid, wcrc_err, er;
  logic [2:0] cmd_op, rd_col, arr_col;
  logic [1:0] cmd_ba;
  logic [13:0] cmd_addr;
  logic [7:0] wbeat_data, arr_data;
  logic rd_vld, rd_oe, arr_we, wr_start, wr_drop, pre_go;
  logic dll_on, dll_locked;
  int n_fail = 0, n_checks = 0, lat = 9;

  // Clock
  always #5 pclk = ~pclk;

  // Block and controller model
  mrb_core #(.DW(8), .TDLLK(TDL)) DUT (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_bg0(cmd_bg0),
    .cmd_ba(cmd_ba), .cmd_addr(cmd_addr), .wbeat_valid(wbeat_valid),
    .wbeat_data(wbeat_data), .wcrc_err(wcrc_err), .rd_vld(rd_vld),
    .rd_oe(rd_oe), .rd_col(rd_col), .arr_we(arr_we), .arr_col(arr_col),
    .arr_data(arr_data), .wr_start(wr_start), .wr_drop(wr_drop),
    .pre_go(pre_go), .dll_on(dll_on), .dll_locked(dll_locked));
  mrb_ctl_model ctl (.pclk(pclk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_bg0(cmd_bg0), .cmd_ba(cmd_ba), .cmd_addr(cmd_addr),
    .wbeat_valid(wbeat_valid), .wbeat_data(wbeat_data),
    .wcrc_err(wcrc_err));

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // A wait that ran out
  task automatic tmo();
    n_fail++;
    $display("[FAIL] %0t wait ran out", $time);
    complete_run();
  endtask

  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask

  // APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
      if (k > 20) tmo();
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register write and read-compare
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv, er);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, rv, er);
    chk(rv, x);
  endtask

  // Wait for DLL lock under a bound
  task automatic wait_lock();
    int k;
    k = 0;
    while (dll_locked !== 1'b1) begin
      @(posedge pclk);
      #1;
      k++;
      if (k > TDL + 20) tmo();
    end
  endtask

  // Read burst: latency, slot enables and column order
  task automatic rd_case(input logic [1:0] bl, input logic bt,
      input logic [2:0] s, input logic a12);
    logic ch;
    logic [2:0] c, m;
    int k;
    ch = (bl == mrb_pkg::BL_FIX4) || (bl == mrb_pkg::BL_OTF && !a12);
    wr(mrb_pkg::ADDR_MR0, {28'h0, bt, 1'b0, bl});
    ctl.send(3'h2, 1'b0, 2'h0, {1'b0, a12, 9'h0, s});
    k = 0;
    do begin
      @(posedge pclk);
      #1;
      k++;
      if (k > 40) tmo();
    end while (rd_vld !== 1'b1);
    chk(k, lat);
    for (int n = 0; n < 8; n++) begin
      m = 3'(n);
      c = bt ? s ^ m : {s[2] ^ m[2], s[1:0] + m[1:0]};
      chk({rd_vld, rd_oe}, (ch && n > 3) ? 2'b00 : 2'b11);
      if (!(ch && n > 3)) chk(rd_col, c);
      @(posedge pclk);
      #1;
    end
  endtask

  // Read with auto-precharge: precharge after AL plus RTP
  task automatic rd_ap_case();
    int k;
    k = 0;
    ctl.send(3'h2, 1'b0, 2'h0, 14'h0400);
    do begin
      @(posedge pclk);
      #1;
      k++;
      if (k > 40) tmo();
    end while (pre_go !== 1'b1);
    chk(k, 5);
    repeat (14) @(posedge pclk);
  endtask

  // Write burst: array words, start point, precharge, drop
  task automatic wr_case(input logic [13:0] m0, input logic [13:0] a,
      input logic err, output int ts, output int tp);
    logic ch, dr;
    int n;
    ch = (m0[1:0] == mrb_pkg::BL_FIX4) ||
      (m0[1:0] == mrb_pkg::BL_OTF && !a[12]);
    n = 0;
    dr = 1'b0;
    ts = 0;
    tp = 0;
    wr(mrb_pkg::ADDR_MR0, {18'h0, m0});
    fork
      ctl.wburst(a, err);
      for (int i = 1; i < 60; i++) begin
        @(posedge pclk);
        #1;
        if (wr_start === 1'b1) ts = i;
        if (pre_go === 1'b1) tp = i;
        if (wr_drop === 1'b1) dr = 1'b1;
        if (arr_we === 1'b1) begin
          chk(arr_col, ch ? {a[2], 2'(n)} : 3'(n));
          chk(arr_data, 8'h10 + 8'(n));
          n++;
        end
      end
    join
    chk(n, err ? 0 : ch ? 4 : 8);
    chk(dr, err);
  endtask

  // Main sequence
  initial begin
    int t8, p8, tf, pf, to, po, t6, p6;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(mrb_pkg::ADDR_MR0, 32'h0);
    rdc(mrb_pkg::ADDR_MR1, 32'h0);
    rdc(mrb_pkg::ADDR_CTRL, 32'h9);
    rdc(mrb_pkg::ADDR_STAT, 32'h0);
    rdc(8'h10, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, 8'h02, 32'hffff, rv, er);
    chk(er, 1'b1);
    wr(mrb_pkg::ADDR_CTRL, 32'h1009);
    rdc(mrb_pkg::ADDR_STAT, 32'h10);
    wr(mrb_pkg::ADDR_CTRL, 32'h9);
    wr(mrb_pkg::ADDR_MR1, 32'h1);
    ctl.send(3'h1, 1'b0, 2'h0, 14'h0100);
    chk(dll_locked, 1'b0);
    rdc(mrb_pkg::ADDR_MR0, 32'h0);
    wait_lock();
    rdc(mrb_pkg::ADDR_STAT, 32'h3);
    ctl.send(3'h1, 1'b1, 2'h3, 14'h0002);
    rdc(mrb_pkg::ADDR_MR0, 32'h0);
    rdc(mrb_pkg::ADDR_MR1, 32'h1);
    ctl.send(3'h4, 1'b0, 2'h0, 14'h0000);
    repeat (4) @(posedge pclk);
    #1;
    chk(dll_on, 1'b0);
    ctl.send(3'h5, 1'b0, 2'h0, 14'h0000);
    wait_lock();
    chk(dll_on, 1'b1);
    rd_case(mrb_pkg::BL_FIX8, 1'b0, 3'h3, 1'b0);
    rd_case(mrb_pkg::BL_FIX8, 1'b1, 3'h5, 1'b0);
    rd_case(mrb_pkg::BL_FIX4, 1'b0, 3'h6, 1'b1);
    rd_case(mrb_pkg::BL_OTF, 1'b1, 3'h1, 1'b0);
    rd_case(mrb_pkg::BL_OTF, 1'b0, 3'h7, 1'b1);
    rd_ap_case();
    wr(mrb_pkg::ADDR_CTRL, 32'h5);
    lat = 5;
    rd_case(mrb_pkg::BL_FIX8, 1'b1, 3'h2, 1'b0);
    wr(mrb_pkg::ADDR_CTRL, 32'h49);
    lat = 11;
    rd_case(mrb_pkg::BL_FIX8, 1'b0, 3'h0, 1'b0);
    wr(mrb_pkg::ADDR_CTRL, 32'h9);
    wr_case(14'h0008, 14'h0405, 1'b0, t8, p8);
    wr_case(14'h0002, 14'h0404, 1'b0, tf, pf);
    wr_case(14'h0001, 14'h0407, 1'b0, to, po);
    chk(tf, t8 - 2);
    chk(to, t8);
    wr_case(14'h0c00, 14'h0400, 1'b0, t6, p6);
    chk(p6 - t6, p8 - t8 + 14);
    wr(mrb_pkg::ADDR_MR0, 32'h0e00);
    rdc(mrb_pkg::ADDR_STAT, 32'hb);
    wr(mrb_pkg::ADDR_CTRL, 32'hc09);
    wr_case(14'h0000, 14'h0400, 1'b1, t6, p6);
    rdc(mrb_pkg::ADDR_STAT, 32'h23);
    complete_run();
  end
endmodule

// file: verif/mrb_ctl_model.sv
// Controller-side model: command strobes and write beats.
// Assumes the block samples these outputs on rising pclk.
module mrb_ctl_model (
  // Clock
  input wire logic pclk,
  // Command port
  output logic cmd_valid,
  output logic [2:0] cmd_op,
  output logic cmd_bg0,
  output logic [1:0] cmd_ba,
  output logic [13:0] cmd_addr,
  // Write beats
  output logic wbeat_valid,
  output logic [7:0] wbeat_data,
  output logic wcrc_err
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle values at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_bg0 = 1'b0;
    cmd_ba = 2'h0;
    cmd_addr = 14'h0000;
    wbeat_valid = 1'b0;
    wbeat_data = 8'h00;
    wcrc_err = 1'b0;
  end

  // One command strobe; mode values are cleaned before they go out
  task automatic send(input logic [2:0] op, input logic bg0,
      input logic [1:0] ba, input logic [13:0] a);
    if (op == 3'h1 && !bg0 && ba == 2'h0) a[7] = 1'b0;
    if (op == 3'h1 && !bg0 && ba == 2'h1) a = a & 14'h3dbb;
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_bg0 <= bg0;
    cmd_ba <= ba;
    cmd_addr <= a;
    @(posedge pclk);
    cmd_valid <= 1'b0;
    cmd_addr <= ~a;
  endtask

  // Write command, then eight beats; mode register 2 never touched
  task automatic wburst(input logic [13:0] a, input logic err);
    send(3'h3, 1'b0, 2'h0, a);
    for (int i = 0; i < 8; i++) begin
      wbeat_valid <= 1'b1;
      wbeat_data <= 8'h10 + 8'(i);
      wcrc_err <= err && (i == 7);
      @(posedge pclk);
    end
    wbeat_valid <= 1'b0;
    wbeat_data <= 8'he8;
    wcrc_err <= 1'b0;
  endtask
endmodule
